// ---- rtl/cinc_nest_ctrl.v ----
// interrupt acceptance and nesting control
//
// Behaviour
// [RL1] issued instructions finish through fifth execute stage
// [RL2] unissued instructions annulled, refetched after return
// [RL3] refetch ignores delay slots of finished instructions
// [RL4] service routine entry leaves interrupts disabled
// [RL5] nonmaskable pre-empts maskable routines four to fifteen
// [RL6] nothing pre-empts a nonmaskable routine
// [RL7] software saves pointer and saved enable first
// [RL8] software clears global enable before restoring
// [RL9] nested maskable entry overwrites saved enable
// [RL10] table pointer gives highest pending fetch packet
// [RL11] table pointer holds highest pending number field
// [RL12] one bit written clears that pending flag
// [RL13] maskable return pointer freely writable, used
// [RL14] five registers may predicate an instruction
// [RL15] displacement branch reaches 21-bit offset only
// [RL16] taken branch runs five delay slot packets
// [RL17] maskable entry saves global enable, clears it
// [RL18] nonmaskable entry clears nonmaskable enable
// [RL19] flag stays until cleared or processed
// [RL20] global enable is control status bit zero
`timescale 1ns/1ps
`default_nettype none
`include "cinc_defines.vh"
module cinc_nest_ctrl (
  // clock and reset
  input  wire        i_clk,
  input  wire        i_sys_rst,
  // interrupt sources, asynchronous levels
  input  wire [15:0] i_irq_pin,
  // control register writes from the pipeline
  input  wire        i_csr_we,
  input  wire [31:0] i_csr_wdata,
  input  wire        i_ier_we,
  input  wire [15:0] i_ier_wdata,
  input  wire        i_flag_clear_we,
  input  wire [15:0] i_flag_clear_wdata,
  input  wire        i_irp_we,
  input  wire [31:0] i_irp_wdata,
  input  wire        i_nrp_we,
  input  wire [31:0] i_nrp_wdata,
  input  wire        i_service_table_pointer_we,
  input  wire [31:0] i_service_table_pointer_wdata,
  input  wire        i_nonmaskable_enable_set,
  // pipeline status
  input  wire        i_e1_valid,
  input  wire [31:0] i_e1_pc,
  input  wire [31:0] i_next_pc,
  input  wire        i_ret_maskable,
  input  wire        i_ret_nonmaskable,
  // branch request
  input  wire        i_br_valid,
  input  wire [2:0]  i_br_creg,
  input  wire        i_br_zero,
  input  wire [4:0]  i_cond_nz,
  input  wire        i_br_disp,
  input  wire [31:0] i_br_offset,
  // register views
  output reg  [31:0] o_csr,
  output reg  [15:0] o_pending_flag_register,
  output reg  [15:0] o_irq_enable_register,
  output reg  [31:0] o_irp,
  output reg  [31:0] o_nonmaskable_return_pointer,
  output reg  [31:0] o_service_table_pointer,
  // pipeline control
  output reg         o_annul,
  output reg         o_drain,
  output reg         o_redirect,
  output reg  [31:0] o_redirect_pc,
  output reg         o_no_slot_hold,
  output reg         o_iack,
  output reg  [4:0]  o_inum,
  output reg         o_br_taken,
  output reg         o_br_range_err,
  output reg         o_br_resolved
);
  // ****************************************
  // state and synchronisers
  // ****************************************
  localparam ST_RUN   = 2'h0;
  localparam ST_DRAIN = 2'h1;
  localparam ST_VEC   = 2'h2;

  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [2:0]  drain_reg;
  reg  [4:0]  take_num_reg;
  reg  [15:0] sync1_reg;
  reg  [15:0] sync2_reg;
  reg  [15:0] prev_reg;
  reg         gie_reg;
  reg         saved_global_enable_reg;
  reg         nonmaskable_enable_reg;
  reg  [15:0] flag_reg;
  reg  [15:0] ier_reg;
  reg  [31:0] irp_reg;
  reg  [31:0] nrp_reg;
  reg  [21:0] tbase_reg;
  reg  [31:0] ret_pc_reg;

  wire [15:0] rise = sync2_reg & ~prev_reg;
  wire [15:0] cand;
  wire        hp_any;
  wire [4:0]  hp_num;
  wire [15:0] poll_cand;
  wire [4:0]  poll_num;
  wire        br_taken;
  wire        br_range_err;
  wire        br_busy;
  wire        br_redirect;

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      sync1_reg <= 16'h0000;
      sync2_reg <= 16'h0000;
      prev_reg  <= 16'h0000;
    end else begin
      sync1_reg <= i_irq_pin;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // ****************************************
  // priority selection
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < `CINC_NUM_IRQ; g = g + 1) begin : g_cand
      if (g == `CINC_NMI_NUM) begin : g_nmi
        assign cand[g]      = flag_reg[g] & nonmaskable_enable_reg; // [RL6]
        assign poll_cand[g] = flag_reg[g] & ier_reg[g];
      end else if (g >= `CINC_FIRST_MASK) begin : g_mask
        assign cand[g]      = flag_reg[g] & ier_reg[g] & gie_reg & nonmaskable_enable_reg; // [RL5]
        assign poll_cand[g] = flag_reg[g] & ier_reg[g];
      end else begin : g_rsvd
        assign cand[g]      = 1'b0;
        assign poll_cand[g] = 1'b0;
      end
    end
  endgenerate

  cinc_priority u_prio (
    .i_cand (cand),
    .o_any  (hp_any),
    .o_num  (hp_num)
  );

  // polled view ignores the global enables, so software can poll with them off
  cinc_priority u_poll (
    .i_cand (poll_cand),
    .o_any  (),
    .o_num  (poll_num)
  );

  cinc_branch_unit u_branch (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_br_valid  (i_br_valid),
    .i_br_creg   (i_br_creg),
    .i_br_zero   (i_br_zero),
    .i_cond_nz   (i_cond_nz),
    .i_br_disp   (i_br_disp),
    .i_br_offset (i_br_offset),
    .o_taken     (br_taken),
    .o_range_err (br_range_err),
    .o_busy      (br_busy),
    .o_redirect  (br_redirect)
  );

  // pending interrupts wait for outstanding branch delay slots
  wire take = (state_reg == ST_RUN) & hp_any & ~br_busy & ~br_taken;

  // ****************************************
  // acceptance sequence
  // ****************************************
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN:   if (take) state_next = ST_DRAIN;
      ST_DRAIN: if (drain_reg == 3'h1) state_next = ST_VEC;
      ST_VEC:   state_next = ST_RUN;
      default:  state_next = ST_RUN;
    endcase
  end

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_reg    <= ST_RUN;
      drain_reg    <= 3'h0;
      take_num_reg <= 5'h00;
      ret_pc_reg   <= `CINC_ZERO32;
    end else begin
      state_reg <= state_next;
      if (take) begin
        drain_reg    <= `CINC_DRAIN_STAGES; // [RL1]
        take_num_reg <= hp_num;
        ret_pc_reg   <= i_e1_valid ? i_next_pc : i_e1_pc; // [RL2]
      end else if (drain_reg != 3'h0) begin
        drain_reg <= drain_reg - 3'h1;
      end
    end
  end

  // ****************************************
  // enables and pending flags
  // ****************************************
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      gie_reg  <= 1'b0;
      saved_global_enable_reg <= 1'b0;
      nonmaskable_enable_reg <= 1'b0;
      ier_reg  <= 16'h0000;
      flag_reg <= 16'h0000;
    end else begin
      if (i_csr_we) begin
        gie_reg  <= i_csr_wdata[`CINC_CSR_GIE_BIT]; // [RL20]
        saved_global_enable_reg <= i_csr_wdata[`CINC_CSR_SAVED_GLOBAL_ENABLE_BIT];
      end
      if (i_ier_we)
        ier_reg <= i_ier_wdata;
      if (i_nonmaskable_enable_set | i_ret_nonmaskable)
        nonmaskable_enable_reg <= 1'b1;
      if (take) begin
        if (hp_num == `CINC_NMI_NUM) begin
          nonmaskable_enable_reg <= 1'b0; // [RL18]
        end else begin
          saved_global_enable_reg <= gie_reg; // [RL17] [RL9]
          gie_reg  <= 1'b0; // [RL4]
        end
      end
      // set wins over clear; take consumes the flag
      flag_reg <= (flag_reg & ~(i_flag_clear_we ? i_flag_clear_wdata : 16'h0000) &
                   ~(take ? (16'h0001 << hp_num) : 16'h0000)) | rise; // [RL12] [RL19]
    end
  end

  // ****************************************
  // return pointers and table pointer
  // ****************************************
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      irp_reg   <= `CINC_ZERO32;
      nrp_reg   <= `CINC_ZERO32;
      tbase_reg <= 22'h000000;
    end else begin
      if (i_irp_we)
        irp_reg <= i_irp_wdata; // [RL13]
      else if (state_reg == ST_VEC && take_num_reg != `CINC_NMI_NUM)
        irp_reg <= ret_pc_reg;
      if (i_nrp_we)
        nrp_reg <= i_nrp_wdata;
      else if (state_reg == ST_VEC && take_num_reg == `CINC_NMI_NUM)
        nrp_reg <= ret_pc_reg;
      if (i_service_table_pointer_we)
        tbase_reg <= i_service_table_pointer_wdata[31:`CINC_TBASE_LSB];
    end
  end

  wire [31:0] service_table_pointer_val = {tbase_reg, poll_num, 5'h00}; // [RL10] [RL11]

  // ****************************************
  // registered outputs
  // ****************************************
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_csr                        <= `CINC_ZERO32;
      o_pending_flag_register      <= 16'h0000;
      o_irq_enable_register        <= 16'h0000;
      o_irp                        <= `CINC_ZERO32;
      o_nonmaskable_return_pointer <= `CINC_ZERO32;
      o_service_table_pointer      <= `CINC_ZERO32;
      o_annul                      <= 1'b0;
      o_drain                      <= 1'b0;
      o_redirect                   <= 1'b0;
      o_redirect_pc                <= `CINC_ZERO32;
      o_no_slot_hold               <= 1'b0;
      o_iack                       <= 1'b0;
      o_inum                       <= 5'h00;
      o_br_taken                   <= 1'b0;
      o_br_range_err               <= 1'b0;
      o_br_resolved                <= 1'b0;
    end else begin
      o_csr                        <= {30'h00000000, saved_global_enable_reg, gie_reg};
      o_pending_flag_register      <= flag_reg;
      o_irq_enable_register        <= ier_reg;
      o_irp                        <= irp_reg;
      o_nonmaskable_return_pointer <= nrp_reg;
      o_service_table_pointer      <= service_table_pointer_val;
      o_annul                      <= take; // [RL2]
      o_drain                      <= (state_next == ST_DRAIN); // [RL1]
      o_iack                       <= (state_reg == ST_VEC);
      o_inum                       <= (state_reg == ST_VEC) ? take_num_reg : 5'h00;
      o_br_taken                   <= br_taken;
      o_br_range_err               <= br_range_err;
      o_br_resolved                <= br_redirect;
      o_redirect                   <= (state_reg == ST_VEC) | i_ret_maskable | i_ret_nonmaskable;
      if (state_reg == ST_VEC)
        o_redirect_pc <= {tbase_reg, take_num_reg, 5'h00};
      else if (i_ret_nonmaskable)
        o_redirect_pc <= nrp_reg;
      else if (i_ret_maskable)
        o_redirect_pc <= irp_reg; // [RL13]
      // returning refetch starts clean, no inherited delay slots
      o_no_slot_hold <= i_ret_maskable | i_ret_nonmaskable; // [RL3]
    end
  end
endmodule
`default_nettype wire

// ---- rtl/cinc_defines.vh ----
// constants for the interrupt nesting control block
`ifndef CINC_DEFINES_VH
`define CINC_DEFINES_VH
`define CINC_NUM_IRQ       16
`define CINC_FIRST_MASK    4
`define CINC_NMI_NUM       1
`define CINC_CSR_GIE_BIT   0
`define CINC_CSR_SAVED_GLOBAL_ENABLE_BIT  1
`define CINC_HPN_LSB       5
`define CINC_HPN_MSB       9
`define CINC_TBASE_LSB     10
`define CINC_DRAIN_STAGES  3'h5
`define CINC_DELAY_SLOTS   3'h5
`define CINC_DISP_BITS     21
`define CINC_NUM_CREG      5
`define CINC_ZERO32        32'h00000000
`endif

// ---- rtl/cinc_priority.v ----
// picks the highest-priority pending enabled interrupt
`timescale 1ns/1ps
`default_nettype none
`include "cinc_defines.vh"
module cinc_priority (
  // candidate vector
  input  wire [15:0] i_cand,
  // result
  output reg         o_any,
  output reg  [4:0]  o_num
);
  integer k;
  always @* begin
    o_any = 1'b0;
    o_num = 5'h00;
    for (k = `CINC_NUM_IRQ - 1; k >= 1; k = k - 1) begin
      if (i_cand[k]) begin
        o_any = 1'b1;
        o_num = k[4:0];
      end
    end
  end
endmodule
`default_nettype wire

// ---- rtl/cinc_branch_unit.v ----
// predicate select, displacement reach and delay slot count for branches
`timescale 1ns/1ps
`default_nettype none
`include "cinc_defines.vh"
module cinc_branch_unit (
  // clock and reset
  input  wire        i_clk,
  input  wire        i_sys_rst,
  // branch request
  input  wire        i_br_valid,
  input  wire [2:0]  i_br_creg,
  input  wire        i_br_zero,
  input  wire [4:0]  i_cond_nz,
  input  wire        i_br_disp,
  input  wire [31:0] i_br_offset,
  // result
  output wire        o_taken,
  output wire        o_range_err,
  output wire        o_busy,
  output reg         o_redirect
);
  reg  [2:0] slot_reg;
  reg  [2:0] slot_next;
  reg        cond;
  wire [31:0] hi_bits;
  assign hi_bits = i_br_offset >> (`CINC_DISP_BITS - 1);
  always @* begin
    case (i_br_creg)
      3'h0:    cond = 1'b1;
      3'h1:    cond = i_cond_nz[0];
      3'h2:    cond = i_cond_nz[1];
      3'h3:    cond = i_cond_nz[2];
      3'h4:    cond = i_cond_nz[3];
      3'h5:    cond = i_cond_nz[4];
      default: cond = 1'b0;
    endcase
  end
  wire pred = i_br_zero ? ~cond : cond; // [RL14]
  // offsets beyond a signed 21-bit field need a register branch
  assign o_range_err = i_br_valid & i_br_disp & (hi_bits != `CINC_ZERO32) &
                       (hi_bits != (32'hffffffff >> (`CINC_DISP_BITS - 1))); // [RL15]
  assign o_taken = i_br_valid & pred & ~o_range_err & (slot_reg == 3'h0);
  assign o_busy  = (slot_reg != 3'h0);
  always @* begin
    slot_next = slot_reg;
    if (o_taken)
      slot_next = `CINC_DELAY_SLOTS; // [RL16]
    else if (slot_reg != 3'h0)
      slot_next = slot_reg - 3'h1;
  end
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      slot_reg   <= 3'h0;
      o_redirect <= 1'b0;
    end else begin
      slot_reg   <= slot_next;
      o_redirect <= (slot_reg == 3'h1);
    end
  end
endmodule
`default_nettype wire

// ---- test/cinc_src_model.sv ----
// interrupt source model: raises lines and drops each once acknowledged
`timescale 1ns/1ps
`default_nettype none
module cinc_src_model (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // requests and acknowledge
  input  wire logic [15:0] i_fire,
  input  wire logic        i_iack,
  input  wire logic [4:0]  i_inum,
  // interrupt lines
  output var  logic [15:0] o_irq_pin
);
  // level held until the acknowledge names this line
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_irq_pin <= 16'h0000;
    end else begin
      o_irq_pin <= (o_irq_pin | i_fire) & ~(i_iack ? (16'h0001 << i_inum) : 16'h0000);
    end
  end
endmodule
`default_nettype wire

// ---- test/cinc_nest_ctrl_sva.sv ----
// checker for the interrupt nesting control block
`timescale 1ns/1ps
`default_nettype none
module cinc_nest_ctrl_sva (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  // watched ports
  input wire logic [15:0] i_irq_pin,
  input wire logic        i_csr_we,
  input wire logic [31:0] i_csr_wdata,
  input wire logic        i_flag_clear_we,
  input wire logic [15:0] i_flag_clear_wdata,
  input wire logic        i_irp_we,
  input wire logic [31:0] i_irp_wdata,
  input wire logic [31:0] o_csr,
  input wire logic [15:0] o_pending_flag_register,
  input wire logic [31:0] o_irp,
  input wire logic [31:0] o_service_table_pointer,
  input wire logic        o_annul,
  input wire logic        o_drain,
  input wire logic        o_redirect,
  input wire logic        o_iack,
  input wire logic [4:0]  o_inum,
  input wire logic        o_br_taken,
  input wire logic        o_br_resolved
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  annul_with_drain_a: assert property (o_annul |-> o_drain)
    else $error("annul seen without drain");
  drain_length_a: assert property ($rose(o_drain) |-> o_drain[*5] ##1 !o_drain)
    else $error("drain not five cycles");
  iack_delay_a: assert property (o_annul |-> ##6 (o_iack && o_redirect))
    else $error("acknowledge not six after annul");
  entry_disabled_a: assert property ((o_iack && o_inum >= 5'h04) |-> !o_csr[0])
    else $error("global enable set at maskable entry");
  flag_clear_a: assert property ($stable(i_irq_pin)[*5] ##0 i_flag_clear_we |-> ##2
    ((o_pending_flag_register & $past(i_flag_clear_wdata, 2)) == 16'h0000)) else $error("flag not cleared");
  table_low_zero_a: assert property (o_service_table_pointer[4:0] == 5'h00)
    else $error("table pointer low bits set");
  irp_write_a: assert property (i_irp_we |-> ##2 o_irp == $past(i_irp_wdata, 2))
    else $error("return pointer write lost");
  slot_count_a: assert property (o_br_taken |-> ##6 o_br_resolved)
    else $error("branch not resolved after five slots");
  csr_write_a: assert property ((i_csr_we && !o_drain && !o_annul) ##1 !o_annul |-> ##1
    o_csr[1:0] == $past(i_csr_wdata[1:0], 2)) else $error("control write lost");
endmodule
bind cinc_nest_ctrl cinc_nest_ctrl_sva cinc_nest_ctrl_sva_inst (.i_clk, .i_sys_rst, .i_irq_pin, .i_csr_we,
  .i_csr_wdata, .i_flag_clear_we, .i_flag_clear_wdata, .i_irp_we, .i_irp_wdata, .o_csr, .o_pending_flag_register,
  .o_irp, .o_service_table_pointer, .o_annul, .o_drain, .o_redirect, .o_iack, .o_inum, .o_br_taken, .o_br_resolved);
`default_nettype wire

// ---- test/cinc_nest_ctrl_bench.sv ----
// bench for the interrupt nesting control block
`timescale 1ns/1ps
`default_nettype none
module cinc_nest_ctrl_bench;
  typedef struct packed {
    logic [2:0]  creg;
    logic        zero;
    logic [4:0]  cond;
    logic        disp;
    logic [31:0] off;
    logic        tk;
    logic        er;
  } cinc_row_t;
  logic        i_clk, i_sys_rst, i_csr_we, i_ier_we, i_flag_clear_we, i_irp_we, i_nrp_we, i_service_table_pointer_we, i_nonmaskable_enable_set;
  logic        i_e1_valid, i_ret_maskable, i_ret_nonmaskable, i_br_valid, i_br_zero, i_br_disp, t, e;
  logic [31:0] i_csr_wdata, i_irp_wdata, i_nrp_wdata, i_service_table_pointer_wdata, i_e1_pc, i_next_pc, i_br_offset;
  logic [15:0] i_ier_wdata, i_flag_clear_wdata, fire;
  logic [4:0]  i_cond_nz;
  logic [2:0]  i_br_creg;
  wire  [15:0] i_irq_pin, o_pending_flag_register, o_irq_enable_register;
  wire  [31:0] o_csr, o_irp, o_service_table_pointer, o_redirect_pc, o_nonmaskable_return_pointer;
  wire  [4:0]  o_inum;
  wire         o_annul, o_drain, o_redirect, o_iack, o_br_taken, o_br_range_err, o_no_slot_hold;
  wire  [2:0]  ev = {o_redirect, o_annul, o_iack};
  int          fails = 0, samples_checked = 0, cyc = 0, n;
  cinc_row_t   rows [14] = '{'{3'h0, 1'b0, 5'h00, 1'b0, 32'h0, 1'b1, 1'b0}, '{3'h1, 1'b0, 5'h01, 1'b0, 32'h0, 1'b1, 1'b0},
    '{3'h2, 1'b0, 5'h02, 1'b0, 32'h0, 1'b1, 1'b0}, '{3'h3, 1'b0, 5'h04, 1'b0, 32'h0, 1'b1, 1'b0},
    '{3'h4, 1'b0, 5'h08, 1'b0, 32'h0, 1'b1, 1'b0}, '{3'h5, 1'b0, 5'h10, 1'b0, 32'h0, 1'b1, 1'b0},
    '{3'h1, 1'b0, 5'h1e, 1'b0, 32'h0, 1'b0, 1'b0}, '{3'h2, 1'b1, 5'h02, 1'b0, 32'h0, 1'b0, 1'b0},
    '{3'h3, 1'b1, 5'h00, 1'b0, 32'h0, 1'b1, 1'b0}, '{3'h6, 1'b0, 5'h1f, 1'b0, 32'h0, 1'b0, 1'b0},
    '{3'h7, 1'b0, 5'h1f, 1'b0, 32'h0, 1'b0, 1'b0}, '{3'h0, 1'b0, 5'h00, 1'b1, 32'h000fffff, 1'b1, 1'b0},
    '{3'h0, 1'b0, 5'h00, 1'b1, 32'h00100000, 1'b0, 1'b1}, '{3'h0, 1'b0, 5'h00, 1'b1, 32'hfff00000, 1'b1, 1'b0}};

  cinc_nest_ctrl cinc_nest_ctrl_inst (.i_clk, .i_sys_rst, .i_irq_pin, .i_csr_we, .i_csr_wdata, .i_ier_we, .i_ier_wdata,
    .i_flag_clear_we, .i_flag_clear_wdata, .i_irp_we, .i_irp_wdata, .i_nrp_we, .i_nrp_wdata, .i_service_table_pointer_we, .i_service_table_pointer_wdata,
    .i_nonmaskable_enable_set, .i_e1_valid, .i_e1_pc, .i_next_pc, .i_ret_maskable, .i_ret_nonmaskable, .i_br_valid, .i_br_creg,
    .i_br_zero, .i_cond_nz, .i_br_disp, .i_br_offset, .o_csr, .o_pending_flag_register, .o_irq_enable_register, .o_irp,
    .o_nonmaskable_return_pointer, .o_service_table_pointer, .o_annul, .o_drain, .o_redirect, .o_redirect_pc,
    .o_no_slot_hold, .o_iack, .o_inum, .o_br_taken, .o_br_range_err, .o_br_resolved());
  cinc_src_model cinc_src_model_inst (.i_clk, .i_sys_rst, .i_fire(fire), .i_iack(o_iack), .i_inum(o_inum),
    .o_irq_pin(i_irq_pin));

  // ****************
  // helpers
  // ****************
  task automatic tick(int k = 1);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // k: 0 csr, 1 irp, 2 table, 3 enable, 4 clear, 5 return, 6 nmi return, 7 nmi enable
  task automatic wr(int k, logic [31:0] d);
    @(posedge i_clk);
    {i_csr_wdata, i_irp_wdata, i_service_table_pointer_wdata} <= {3{d}};
    {i_ier_wdata, i_flag_clear_wdata} <= {2{d[15:0]}};
    {i_nonmaskable_enable_set, i_ret_nonmaskable, i_ret_maskable, i_flag_clear_we, i_ier_we, i_service_table_pointer_we, i_irp_we, i_csr_we} <= 8'h01 << k;
    @(posedge i_clk);
    {i_nonmaskable_enable_set, i_ret_nonmaskable, i_ret_maskable, i_flag_clear_we, i_ier_we, i_service_table_pointer_we, i_irp_we, i_csr_we} <= 8'h00;
  endtask
  task automatic raise(int k);
    @(posedge i_clk);
    fire <= 16'h0001 << k;
    @(posedge i_clk);
    fire <= 16'h0000;
  endtask
  task automatic await(int b);
    #1;
    n = 0;
    while (ev[b] !== 1'b1 && n < 40) begin
      tick();
      n++;
    end
    chk("await", 1, ev[b]);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails = fails + 1;
      summarize();
    end
  end

  // ****************
  // main sequence
  // ****************
  initial begin
    {i_sys_rst, i_e1_valid, i_csr_we, i_ier_we, i_flag_clear_we, i_irp_we, i_nrp_we, i_service_table_pointer_we} = 8'hc0;
    {i_nonmaskable_enable_set, i_ret_maskable, i_ret_nonmaskable, i_br_valid, i_br_zero, i_br_disp} = 6'h00;
    {i_csr_wdata, i_irp_wdata, i_nrp_wdata, i_service_table_pointer_wdata, i_br_offset, i_ier_wdata} = '0;
    {i_flag_clear_wdata, fire, i_cond_nz, i_br_creg} = '0;
    i_e1_pc = 32'h0000103c;
    i_next_pc = 32'h00001040;
    repeat (8) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    tick();
    chk("csr_rst", 0, o_csr);
    chk("flags_rst", 0, o_pending_flag_register);
    chk("irp_rst", 0, o_irp);
    foreach (rows[i]) begin
      @(posedge i_clk);
      {i_br_creg, i_br_zero, i_cond_nz, i_br_disp, i_br_offset} <= rows[i][43:2];
      i_br_valid <= 1'b1;
      @(posedge i_clk);
      i_br_valid <= 1'b0;
      {t, e} = 2'b00;
      repeat (10) begin
        #1 {t, e} = {t | o_br_taken, e | o_br_range_err};
        @(posedge i_clk);
      end
      chk("br_taken", rows[i].tk, t);
      chk("br_range", rows[i].er, e);
    end
    wr(7, 0);
    wr(3, 32'h0072);
    wr(2, 32'h00008000);
    raise(5);
    tick(8);
    chk("flags", 32'h0020, o_pending_flag_register);
    chk("table", 32'h000080a0, o_service_table_pointer);
    chk("enable", 32'h0072, o_irq_enable_register);
    wr(4, 32'h0020);
    tick(2);
    chk("flags_clr", 0, o_pending_flag_register);
    wr(0, 32'h1);
    raise(4);
    await(1);
    chk("drain", 1, o_drain);
    tick();
    chk("csr_entry", 2, o_csr[1:0]);
    tick(5);
    chk("inum", 4, o_inum);
    chk("vec_pc", 32'h00008080, o_redirect_pc);
    tick();
    chk("irp", 32'h00001040, o_irp);
    tick(2);
    chk("flag4", 0, o_pending_flag_register[4]);
    raise(1);
    i_e1_valid <= 1'b0;
    await(1);
    tick(6);
    chk("inum_nmi", 1, o_inum);
    tick();
    chk("nrp", 32'h0000103c, o_nonmaskable_return_pointer);
    wr(0, 32'h1);
    raise(6);
    t = 1'b0;
    repeat (20) begin
      tick();
      t |= o_annul;
    end
    chk("nmi_block", 0, t);
    wr(6, 0);
    await(1);
    tick();
    chk("csr_nest", 2, o_csr[1:0]);
    tick(5);
    chk("inum_nest", 6, o_inum);
    wr(0, 32'h0);
    wr(0, 32'h2);
    wr(1, 32'hdeadbeef);
    tick();
    chk("irp_sw", 32'hdeadbeef, o_irp);
    wr(5, 0);
    await(2);
    chk("ret_pc", 32'hdeadbeef, o_redirect_pc);
    chk("no_hold", 1, o_no_slot_hold);
    summarize();
  end
endmodule
`default_nettype wire
